// file: pkg/charger_pkg.sv
// shared constants for the charger status and control logic
package charger_pkg;
   localparam int unsigned CLOCK_HZ        = 25_000_000;
   // termination comparator filter time, in microseconds
   localparam int unsigned TERM_FILTER_US  = 1000;
   localparam int unsigned TERM_FILTER_CYC = (CLOCK_HZ / 1_000_000) * TERM_FILTER_US;
   // safety timer length in seconds, factory chosen
   localparam int unsigned SAFETY_TIMER_S  = 21600;
   // safety timer prescale: one tick per millisecond
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYC        = (CLOCK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned SAFETY_TICKS    = SAFETY_TIMER_S * 1000;
   // input current limits in milliamps
   localparam logic [11:0] LIMIT_USB_LOW_MA  = 12'h064;
   localparam logic [11:0] LIMIT_USB_HIGH_MA = 12'h1F4;
   localparam logic [11:0] LIMIT_ADAPTER_MA  = 12'h708;
   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_PRECOND,
      ST_CONST_CURRENT,
      ST_CONST_VOLTAGE,
      ST_COMPLETE,
      ST_TIMER_FAULT,
      ST_NO_BATTERY
   } charge_state_t;
endpackage

// file: rtl/level_filter.sv
// holds a high level for a set number of cycles before passing it on
`timescale 1ns/1ns
`default_nettype none
module level_filter #(
   parameter int unsigned CYCLES = 25000
) (
   input  wire logic i_clock,
   input  wire logic i_rst_n,
   input  wire logic i_level,
   output logic      o_held
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   logic [W-1:0] count_q;

   // count while the level stays high, restart on any drop
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_q <= '0;
         o_held  <= 1'b0;
      end else if (!i_level) begin
         count_q <= '0;
         o_held  <= 1'b0;
      end else if (count_q >= W'(CYCLES - 1)) begin
         o_held <= 1'b1;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: rtl/charger_status_control.sv
// charge cycle sequencing, status pin encoding and input limit select
// Notes on behaviour
// R1: outside the thermistor window during charging suspends the cycle at once.
// R2: while suspended the pass element is off and the timer holds.
// R3: back in the window the cycle resumes from the held count.
// R4: status pins are only driven low or released, never high.
// R5: charging shows A low; faults show both low; low battery A only.
// R6: charge complete releases A, drives B low, power-good low.
// R7: no input releases all but A on low battery; input without battery keeps only power-good.
// R8: source select low gives USB limit chosen by the limit select pin.
// R9: source select high gives the adapter limit and programmed current.
// R10: power-good low when input above lockout and above battery.
// R11: power-good only sinks, never sources.
// R12: timer enable low runs the safety timer, high disables it.
// R13: safety timer clears on each entry to constant current.
// R14: timer expiry faults and ends charge until battery removal or loss of input power.
// R15: termination must persist one filter interval before completion.
// R16: in standby a below-recharge reading starts a new cycle.
// R17: precondition, constant current, constant voltage, complete by comparators.
// R18: inputs sampled on the clock; reset returns to shutdown.
`timescale 1ns/1ns
`default_nettype none
module charger_status_control #(
   parameter int unsigned FILTER_CYCLES = charger_pkg::TERM_FILTER_CYC,
   parameter int unsigned TICK_CYCLES   = charger_pkg::TICK_CYC,
   parameter int unsigned TIMER_TICKS   = charger_pkg::SAFETY_TICKS
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   input  wire logic        i_input_above_undervoltage_lockout,
   input  wire logic        i_input_above_battery,
   input  wire logic        i_battery_present,
   input  wire logic        i_low_battery,
   input  wire logic        i_above_precondition,
   input  wire logic        i_at_regulation,
   input  wire logic        i_termination_current,
   input  wire logic        i_below_recharge,
   input  wire logic        i_thermistor_sense_high,
   input  wire logic        i_thermistor_sense_low,
   input  wire logic        i_source_select,
   input  wire logic        i_usb_limit_select,
   input  wire logic        i_timer_enable_n,
   output logic            o_charge_status_a,
   output logic            o_charge_status_a_oe_n,
   output logic            o_charge_status_b,
   output logic            o_charge_status_b_oe_n,
   output logic            o_input_power_good_n,
   output logic            o_input_power_good_oe_n,
   output logic            o_pass_enable,
   output logic            o_precondition_current,
   output logic            o_fast_charge_program,
   output logic [11:0]     o_input_limit_ma,
   output logic            o_timer_running,
   output logic            o_timer_fault
);
   localparam int unsigned TW = $clog2(TIMER_TICKS + 1);
   localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
   charger_pkg::charge_state_t state_q;
   logic          term_held;
   logic          temp_fault;
   logic          charging;
   logic          power_ok;
   logic          tick_q;
   logic [PW-1:0] pre_q;
   logic [TW-1:0] timer_q;
   logic          expired;
   logic          a_low;
   logic          b_low;
   // filter rejects load transients on the termination comparator
   level_filter #(
      .CYCLES (FILTER_CYCLES)
   ) u_term_filter (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_level (i_termination_current),
      .o_held  (term_held)
   ); // R15
   // derived conditions from sampled comparator levels
   assign power_ok   = i_input_above_undervoltage_lockout && i_input_above_battery;
   assign charging   = (state_q == charger_pkg::ST_PRECOND) ||
                       (state_q == charger_pkg::ST_CONST_CURRENT) ||
                       (state_q == charger_pkg::ST_CONST_VOLTAGE);
   assign temp_fault = charging &&
                       (i_thermistor_sense_high || i_thermistor_sense_low); // R1
   assign expired    = (timer_q >= TW'(TIMER_TICKS));
   // charge state sequencing
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= charger_pkg::ST_SHUTDOWN; // R18
      end else if (!power_ok) begin
         state_q <= charger_pkg::ST_SHUTDOWN;
      end else begin
         case (state_q)
            charger_pkg::ST_SHUTDOWN:
               state_q <= i_battery_present ? charger_pkg::ST_PRECOND
                                            : charger_pkg::ST_NO_BATTERY;
            charger_pkg::ST_NO_BATTERY:
               if (i_battery_present) begin
                  state_q <= charger_pkg::ST_PRECOND;
               end
            charger_pkg::ST_PRECOND:
               if (!i_battery_present) begin
                  state_q <= charger_pkg::ST_NO_BATTERY;
               end else if (!temp_fault && i_above_precondition) begin
                  state_q <= charger_pkg::ST_CONST_CURRENT; // R17
               end
            charger_pkg::ST_CONST_CURRENT:
               if (!i_battery_present) begin
                  state_q <= charger_pkg::ST_NO_BATTERY;
               end else if (expired) begin
                  state_q <= charger_pkg::ST_TIMER_FAULT; // R14
               end else if (!temp_fault && i_at_regulation) begin
                  state_q <= charger_pkg::ST_CONST_VOLTAGE; // R17
               end
            charger_pkg::ST_CONST_VOLTAGE:
               if (!i_battery_present) begin
                  state_q <= charger_pkg::ST_NO_BATTERY;
               end else if (expired) begin
                  state_q <= charger_pkg::ST_TIMER_FAULT; // R14
               end else if (!temp_fault && term_held) begin
                  state_q <= charger_pkg::ST_COMPLETE; // R17
               end
            charger_pkg::ST_COMPLETE:
               if (!i_battery_present) begin
                  state_q <= charger_pkg::ST_NO_BATTERY;
               end else if (i_below_recharge) begin
                  state_q <= charger_pkg::ST_PRECOND; // R16
               end
            charger_pkg::ST_TIMER_FAULT:
               // latched until the cell is pulled out or input power is lost
               if (!i_battery_present) begin
                  state_q <= charger_pkg::ST_NO_BATTERY; // R14
               end
            default:
               state_q <= charger_pkg::ST_SHUTDOWN;
         endcase
      end
   end
   // millisecond tick for the safety timer
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end else if (pre_q >= PW'(TICK_CYCLES - 1)) begin
         pre_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         pre_q  <= pre_q + 1'b1;
         tick_q <= 1'b0;
      end
   end
   // safety timer: clears on fast charge entry, holds while suspended
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_q <= '0;
      end else if (state_q != charger_pkg::ST_CONST_CURRENT &&
                   state_q != charger_pkg::ST_CONST_VOLTAGE) begin
         timer_q <= '0; // R13
      end else if (tick_q && !temp_fault && !i_timer_enable_n && !expired) begin
         timer_q <= timer_q + 1'b1; // R12 R3
      end
      // temp_fault leaves the count untouched, so resume continues from it
   end

   // status pin levels per charge state
   always_comb begin
      a_low = 1'b0;
      b_low = 1'b0;
      case (state_q)
         charger_pkg::ST_PRECOND,
         charger_pkg::ST_CONST_CURRENT,
         charger_pkg::ST_CONST_VOLTAGE: begin
            a_low = 1'b1; // R5
            b_low = temp_fault; // R5
         end
         charger_pkg::ST_COMPLETE: begin
            b_low = 1'b1; // R6
         end
         charger_pkg::ST_TIMER_FAULT: begin
            a_low = 1'b1; // R5
            b_low = 1'b1;
         end
         default: begin
            a_low = 1'b0; // R7
            b_low = 1'b0;
         end
      endcase
      if (!power_ok && i_low_battery) begin
         a_low = 1'b1; // R5
      end
   end

   // registered open-drain pins: data always zero, enable low to sink
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_charge_status_a_oe_n  <= 1'b1;
         o_charge_status_b_oe_n  <= 1'b1;
         o_input_power_good_oe_n <= 1'b1;
      end else begin
         o_charge_status_a_oe_n  <= !a_low; // R4
         o_charge_status_b_oe_n  <= !b_low; // R4
         o_input_power_good_oe_n <= !power_ok; // R10 R7
      end
   end

   // data lines are constant low so the pins can never pull high
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_charge_status_a    <= 1'b0;
         o_charge_status_b    <= 1'b0;
         o_input_power_good_n <= 1'b0;
      end else begin
         o_charge_status_a    <= 1'b0; // R4
         o_charge_status_b    <= 1'b0;
         o_input_power_good_n <= 1'b0; // R11
      end
   end

   // pass element and current programming
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pass_enable          <= 1'b0;
         o_precondition_current <= 1'b0;
         o_fast_charge_program  <= 1'b0;
         o_input_limit_ma       <= charger_pkg::LIMIT_USB_LOW_MA;
      end else begin
         o_pass_enable          <= charging && !temp_fault; // R2
         o_precondition_current <= (state_q == charger_pkg::ST_PRECOND);
         o_fast_charge_program  <= i_source_select; // R9
         if (i_source_select) begin
            o_input_limit_ma <= charger_pkg::LIMIT_ADAPTER_MA; // R9
         end else if (i_usb_limit_select) begin
            o_input_limit_ma <= charger_pkg::LIMIT_USB_HIGH_MA; // R8
         end else begin
            o_input_limit_ma <= charger_pkg::LIMIT_USB_LOW_MA; // R8
         end
      end
   end

   // timer status flags
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_timer_running <= 1'b0;
         o_timer_fault   <= 1'b0;
      end else begin
         o_timer_running <= charging && !temp_fault && !i_timer_enable_n; // R12
         o_timer_fault   <= (state_q == charger_pkg::ST_TIMER_FAULT); // R14
      end
   end

   a_status_never_high: assert property ( // R4
      @(posedge i_clock) disable iff (!i_rst_n)
      !o_charge_status_a && !o_charge_status_b && !o_input_power_good_n)
      else $error("status pin driven high");
   a_suspend_pass_off: assert property ( // R2
      @(posedge i_clock) disable iff (!i_rst_n)
      temp_fault |=> !o_pass_enable)
      else $error("pass element on during temperature suspend");
   a_suspend_timer_hold: assert property ( // R2
      @(posedge i_clock) disable iff (!i_rst_n)
      (temp_fault && $past(temp_fault) && charging && $stable(state_q))
      |-> $stable(timer_q))
      else $error("safety timer moved while suspended");
   a_cc_entry_clear: assert property ( // R13
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_q == charger_pkg::ST_CONST_CURRENT &&
       $past(state_q) == charger_pkg::ST_PRECOND) |-> timer_q == '0)
      else $error("timer not cleared on fast charge entry");
   a_timer_disabled: assert property ( // R12
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_timer_enable_n && $past(state_q) == state_q) |=> timer_q <= $past(timer_q))
      else $error("timer advanced while disabled");
   a_fault_latched: assert property ( // R14
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_q == charger_pkg::ST_TIMER_FAULT && i_battery_present && power_ok)
      |=> state_q == charger_pkg::ST_TIMER_FAULT)
      else $error("timer fault left with battery present");
   a_power_good: assert property ( // R10
      @(posedge i_clock) disable iff (!i_rst_n)
      power_ok |=> !o_input_power_good_oe_n)
      else $error("power-good not asserted");
   a_complete_pins: assert property ( // R6
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_q == charger_pkg::ST_COMPLETE && power_ok) |=>
      (o_charge_status_a_oe_n && !o_charge_status_b_oe_n))
      else $error("standby status pins wrong");
   a_usb_limit: assert property ( // R8
      @(posedge i_clock) disable iff (!i_rst_n)
      (!i_source_select && i_usb_limit_select) |=>
      o_input_limit_ma == charger_pkg::LIMIT_USB_HIGH_MA)
      else $error("usb high limit not applied");
   a_recharge_start: assert property ( // R16
      @(posedge i_clock) disable iff (!i_rst_n)
      (state_q == charger_pkg::ST_COMPLETE && power_ok && i_battery_present &&
       i_below_recharge) |=> state_q == charger_pkg::ST_PRECOND)
      else $error("recharge not started");
endmodule
`default_nettype wire

// file: sim/host_model.sv
// host side model: select lines plus pull-ups on the status pins
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic i_clock,
   input  wire logic i_want_adapter,
   input  wire logic i_want_high,
   input  wire logic i_want_timer,
   input  wire logic i_a_oe_n,
   input  wire logic i_a,
   input  wire logic i_b_oe_n,
   input  wire logic i_b,
   input  wire logic i_pg_oe_n,
   input  wire logic i_pg,
   output logic      o_source_select,
   output logic      o_usb_limit_select,
   output logic      o_timer_enable_n,
   output logic      o_a_level,
   output logic      o_b_level,
   output logic      o_pg_level
);
   // selects change just after the edge, as a port write would
   always @(posedge i_clock) begin
      o_source_select <= i_want_adapter;
      o_usb_limit_select <= i_want_high;
      o_timer_enable_n <= !i_want_timer;
   end
   // pull-ups win whenever a pin is released; pin never pulls high itself
   assign o_a_level = i_a_oe_n ? 1'b1 : i_a;
   assign o_b_level = i_b_oe_n ? 1'b1 : i_b;
   assign o_pg_level = i_pg_oe_n ? 1'b1 : i_pg;
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the charger status and control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %0t value differs", $time); end end
module tb;
   logic        i_clock = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        pwr = 1'b0, above_bat = 1'b0, bat = 1'b0, low_bat = 1'b0, above_pre = 1'b0;
   logic        at_reg = 1'b0, term = 1'b0, rech = 1'b0, hot = 1'b0, cold = 1'b0;
   logic        adapter = 1'b0, high = 1'b0, timer = 1'b0;
   logic [9:0]  lv_q;
   logic        ssel, usel, te_n, a_lv, b_lv, pg_lv;
   logic        a, a_oe_n, b, b_oe_n, pg, pg_oe_n, pass, pre_i, fcp, run, fault;
   logic [11:0] limit;
   logic [31:0] lfsr = 32'h0001_0598;
   int          err_total = 0;
   int          checks_done = 0;
   always #20 i_clock = ~i_clock;
   // comparator levels launched on the rising edge, never between edges
   always @(posedge i_clock) begin
      lv_q <= {pwr, above_bat, bat, low_bat, above_pre, at_reg, term, rech, hot, cold};
   end
   // short counts keep the timer expiry near two hundred cycles
   charger_status_control #(.FILTER_CYCLES(8), .TICK_CYCLES(4), .TIMER_TICKS(50))
      charger_status_control_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_input_above_undervoltage_lockout(lv_q[9]), .i_input_above_battery(lv_q[8]), .i_battery_present(lv_q[7]),
      .i_low_battery(lv_q[6]), .i_above_precondition(lv_q[5]), .i_at_regulation(lv_q[4]),
      .i_termination_current(lv_q[3]), .i_below_recharge(lv_q[2]),
      .i_thermistor_sense_high(lv_q[1]), .i_thermistor_sense_low(lv_q[0]),
      .i_source_select(ssel), .i_usb_limit_select(usel),
      .i_timer_enable_n(te_n), .o_charge_status_a(a), .o_charge_status_a_oe_n(a_oe_n),
      .o_charge_status_b(b), .o_charge_status_b_oe_n(b_oe_n), .o_input_power_good_n(pg),
      .o_input_power_good_oe_n(pg_oe_n), .o_pass_enable(pass), .o_precondition_current(pre_i),
      .o_fast_charge_program(fcp), .o_input_limit_ma(limit), .o_timer_running(run),
      .o_timer_fault(fault));
   host_model host_model_inst (.i_clock(i_clock), .i_want_adapter(adapter),
      .i_want_high(high), .i_want_timer(timer), .i_a_oe_n(a_oe_n), .i_a(a),
      .i_b_oe_n(b_oe_n), .i_b(b), .i_pg_oe_n(pg_oe_n), .i_pg(pg), .o_source_select(ssel),
      .o_usb_limit_select(usel), .o_timer_enable_n(te_n), .o_a_level(a_lv),
      .o_b_level(b_lv), .o_pg_level(pg_lv));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected input limit from the two select levels
   function automatic logic [11:0] exp_limit(input logic ad, input logic hi);
      if (ad)
         return charger_pkg::LIMIT_ADAPTER_MA;
      return hi ? charger_pkg::LIMIT_USB_HIGH_MA : charger_pkg::LIMIT_USB_LOW_MA;
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // pin levels after the three-edge latency plus margin; 0 means pulled low
   task automatic pins(input logic ea, input logic eb, input logic epg, input logic ep);
      cyc(4);
      #1;
      `CHK({a, b, pg}, 3'b000)
      `CHK({a_lv, b_lv, pg_lv, pass}, {ea, eb, epg, ep})
   endtask
   // bounded wait for the timer fault flag
   task automatic wait_fault(input int lim);
      int k;
      for (k = 0; k < lim && fault !== 1'b1; k++) begin
         @(posedge i_clock);
         #1;
      end
      if (fault !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t timer wait ran out", $time);
         test_done();
      end
   endtask
   initial begin
      cyc(1);
      #1;
      `CHK({a_oe_n, b_oe_n, pg_oe_n, pass, limit}, {4'hE, charger_pkg::LIMIT_USB_LOW_MA})
      cyc(1);
      i_rst_n <= 1'b1;
      pins(1, 1, 1, 0);
      low_bat <= 1'b1;
      pins(0, 1, 1, 0);
      low_bat <= 1'b0;
      pwr <= 1'b1;
      pins(1, 1, 1, 0);
      above_bat <= 1'b1;
      pins(1, 1, 0, 0);
      bat <= 1'b1;
      pins(0, 1, 0, 1);
      `CHK(pre_i, 1'b1)
      above_pre <= 1'b1;
      pins(0, 1, 0, 1);
      `CHK({pre_i, run}, 2'b00)
      hot <= 1'b1;
      pins(0, 0, 0, 0);
      hot <= 1'b0;
      cold <= 1'b1;
      pins(0, 0, 0, 0);
      cold <= 1'b0;
      pins(0, 1, 0, 1);
      at_reg <= 1'b1;
      term <= 1'b1;
      cyc(3);
      term <= 1'b0;
      pins(0, 1, 0, 1);
      term <= 1'b1;
      cyc(12);
      pins(1, 0, 0, 0);
      term <= 1'b0;
      rech <= 1'b1;
      pins(0, 1, 0, 1);
      rech <= 1'b0;
      at_reg <= 1'b0;
      bat <= 1'b0;
      pins(1, 1, 0, 0);
      // fresh constant current phase with the timer running
      bat <= 1'b1;
      timer <= 1'b1;
      cyc(100);
      #1;
      `CHK({run, fault}, 2'b10)
      hot <= 1'b1;
      cyc(150);
      #1;
      `CHK({fault, pass}, 2'b00)
      hot <= 1'b0;
      cyc(60);
      #1;
      `CHK(fault, 1'b0)
      wait_fault(100);
      pins(0, 0, 0, 0);
      bat <= 1'b0;
      pins(1, 1, 0, 0);
      `CHK(fault, 1'b0)
      bat <= 1'b1;
      cyc(150);
      #1;
      `CHK(fault, 1'b0)
      for (int i = 0; i < 24; i++) begin
         lfsr = next_rand(lfsr);
         adapter <= (i < 4) ? i[1] : lfsr[0];
         high <= (i < 4) ? i[0] : lfsr[1];
         cyc(4);
         #1;
         `CHK(limit, exp_limit(adapter, high))
         `CHK(fcp, adapter)
      end
      test_done();
   end
endmodule
`default_nettype wire
